// ==== core/clk_div_consts.vh ====
`ifndef CLK_DIV_CONSTS_VH
`define CLK_DIV_CONSTS_VH

// Register indices (printed offsets); byte address is four times the index
`define IDX_ROOT_N_MIC 8'h39
`define IDX_ROOT_M_ADC 8'h3A
`define IDX_DAC_BCLK_HI 8'h3B
`define IDX_PRI_BCLK_LO 8'h3C
`define IDX_SEC_BCLK_LO 8'h3D
`define IDX_ANALOG_NM 8'h3E
`define IDX_ENABLES 8'h44
`define IDX_AUTO_DETECT 8'h50

// Reset values
`define RST_ROOT_N_MIC 8'h20
`define RST_ROOT_M_ADC 8'h04
`define RST_DAC_BCLK_HI 8'h00
`define RST_PRI_BCLK_LO 8'h01
`define RST_SEC_BCLK_LO 8'h01
`define RST_ANALOG_NM 8'h01
`define RST_ENABLES 8'h00
`define RST_AUTO_DETECT 8'h00

// Writable bit masks; other bits are reserved and read zero
`define MSK_ROOT_N_MIC 8'hFC
`define MSK_ROOT_M_ADC 8'hFF
`define MSK_DAC_BCLK_HI 8'h3E
`define MSK_ANALOG_NM 8'h3F
`define MSK_ENABLES 8'h07
`define MSK_AUTO_DETECT 8'h01

// Field positions
`define F_ROOT_N_HI 7
`define F_ROOT_N_LO 5
`define F_MIC_HI 4
`define F_MIC_LO 2
`define F_ROOT_M_HI 7
`define F_ROOT_M_LO 2
`define F_ADC_HI 1
`define F_ADC_LO 0
`define F_DAC_HI 5
`define F_DAC_LO 4
`define F_DAC_X2_OFF 3
`define F_PRI_HI 2
`define F_SEC_HI 1
`define F_ANA_HI 5
`define F_ANA_LO 0
`define F_EN_N 2
`define F_EN_M 1
`define F_EN_MIC 0

`endif

// ==== core/audio_clock_divider_config.v ====
`timescale 1ns/1ps
`include "clk_div_consts.vh"

module audio_clock_divider_config #(
    // Ratios used in auto mode; one lets every tap toggle each cycle
    parameter AUTO_N = 9'd1,      // Internal divides used in auto mode
    parameter AUTO_M = 9'd1,
    parameter AUTO_MIC = 9'd1,
    parameter AUTO_MOD = 9'd1,
    parameter AUTO_BCLK = 10'd1,
    parameter AUTO_ANA = 9'd1
) (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    input wire auto_detect_pin,   // Pin asking for automatic detection
    output reg root_n_clk,
    output reg root_m_clk,
    output reg mic_clk,
    output reg adc_mod_clk,
    output reg dac_mod_clk,
    output reg pri_bclk,
    output reg sec_bclk,
    output reg analog_nm_clk,
    output reg auto_active        // Auto detection currently in force
);

    // Eight dividers share one counter scheme and run from pclk. Software
    // sets their ratios through byte-wide registers on the APB word map;
    // auto detection, from a pin or a register bit, overrides every
    // programmed ratio with a fixed internal one. Only the root N, root M
    // and microphone dividers have enable bits of their own; the other
    // five always run, their own enables being kept elsewhere.
    // Limitation: the taps are made by flops, so no tap is faster than
    // half of pclk.
    // Register storage
    reg [7:0] root_n_mic_reg;
    reg [7:0] root_m_adc_reg;
    reg [7:0] dac_bclk_hi_reg;
    reg [7:0] pri_lo_reg;
    reg [7:0] sec_lo_reg;
    reg [7:0] analog_nm_reg;
    reg [7:0] enables_reg;
    reg [7:0] auto_reg;

    // Pin synchroniser: three stages, change counted when 2 and 3 agree
    // The pin is asynchronous to pclk; stage one may go metastable, so
    // only stage two reads it. Waiting for stages two and three to agree
    // costs a cycle but rejects a one-cycle glitch on the pin.
    reg [2:0] pin_sync_reg; // Shift chain, bit 0 nearest the pin
    reg pin_level_reg; // Filtered pin level

    // Shift the pin in and follow it once the last two stages agree
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_sync_reg <= 3'h0;
            pin_level_reg <= 1'b0;
        end else begin
            pin_sync_reg <= {pin_sync_reg[1:0], auto_detect_pin};
            if (pin_sync_reg[2] == pin_sync_reg[1]) begin
                pin_level_reg <= pin_sync_reg[2];
            end
        end
    end

    // Auto detection is in force when the pin or the register asks for it
    // This level steers the ratios directly, without a further flop
    wire auto_on = pin_level_reg | auto_reg[0];

    // Status output registered so the port comes straight from a flop;
    // it trails auto_on, which steers the ratios, by one cycle
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            auto_active <= 1'b0;
        end else begin
            auto_active <= auto_on;
        end
    end

    // Decode of the APB word address into a register index
    // Each register is one byte in the low lane of an aligned word;
    // bits 11:10 must be zero so the map does not alias higher up
    wire addr_ok = (paddr[1:0] == 2'b00) && (paddr[11:10] == 2'b00);
    wire [7:0] idx = paddr[9:2];
    reg hit;
    reg [7:0] rd_byte;

    // Read multiplexer; reserved bits are stored as zero so read zero
    // An index outside the map clears hit, which refuses the transfer
    always @* begin
        hit = addr_ok;
        rd_byte = 8'h00;
        case (idx)
            `IDX_ROOT_N_MIC: rd_byte = root_n_mic_reg;
            `IDX_ROOT_M_ADC: rd_byte = root_m_adc_reg;
            `IDX_DAC_BCLK_HI: rd_byte = dac_bclk_hi_reg;
            `IDX_PRI_BCLK_LO: rd_byte = pri_lo_reg;
            `IDX_SEC_BCLK_LO: rd_byte = sec_lo_reg;
            `IDX_ANALOG_NM: rd_byte = analog_nm_reg;
            `IDX_ENABLES: rd_byte = enables_reg;
            `IDX_AUTO_DETECT: rd_byte = auto_reg;
            default: hit = 1'b0;
        endcase
    end

    // APB slave: one wait state, answer in the second access cycle.
    // pready is a flop, so the first access edge only arms the answer;
    // the write lands on the edge at which pready is seen high, while
    // the master still holds address and data. This costs one cycle per
    // transfer but keeps every output port registered.
    wire access = psel && penable && !pready; // First access cycle
    wire wr_en = psel && penable && pready && pwrite && hit; // Commit
    wire [7:0] wd = pwdata[7:0]; // Registers use byte lane 0 only

    // Answer flops; prdata keeps the last read until the next one
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end else begin
            pready <= access;
            pslverr <= access && !hit;
            if (access && !pwrite) begin
                prdata <= {24'h000000, rd_byte};
            end
        end
    end

    // Register writes; reserved bits masked off on the way in
    // Masking here rather than at read time means a stray write of
    // ones to a reserved bit can never reach the decode below
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            root_n_mic_reg <= `RST_ROOT_N_MIC;
            root_m_adc_reg <= `RST_ROOT_M_ADC;
            dac_bclk_hi_reg <= `RST_DAC_BCLK_HI;
            pri_lo_reg <= `RST_PRI_BCLK_LO;
            sec_lo_reg <= `RST_SEC_BCLK_LO;
            analog_nm_reg <= `RST_ANALOG_NM;
            enables_reg <= `RST_ENABLES;
            auto_reg <= `RST_AUTO_DETECT;
        end else if (wr_en) begin
            case (idx)
                `IDX_ROOT_N_MIC: root_n_mic_reg <= wd & `MSK_ROOT_N_MIC;
                `IDX_ROOT_M_ADC: root_m_adc_reg <= wd & `MSK_ROOT_M_ADC;
                `IDX_DAC_BCLK_HI: dac_bclk_hi_reg <= wd & `MSK_DAC_BCLK_HI;
                `IDX_PRI_BCLK_LO: pri_lo_reg <= wd;
                `IDX_SEC_BCLK_LO: sec_lo_reg <= wd;
                `IDX_ANALOG_NM: analog_nm_reg <= wd & `MSK_ANALOG_NM;
                `IDX_ENABLES: enables_reg <= wd & `MSK_ENABLES;
                `IDX_AUTO_DETECT: auto_reg <= wd & `MSK_AUTO_DETECT;
                default: auto_reg <= auto_reg;
            endcase
        end
    end

    // Field decode into divide ratios
    // Plain slices of the stored bytes; reserved bits are never read here.
    // The bit clock codes are nine bits wide: one high bit shared in the
    // DAC register above an eight-bit low register of their own.
    wire [2:0] n_code = root_n_mic_reg[`F_ROOT_N_HI:`F_ROOT_N_LO];
    wire [2:0] mic_code = root_n_mic_reg[`F_MIC_HI:`F_MIC_LO];
    wire [5:0] m_code = root_m_adc_reg[`F_ROOT_M_HI:`F_ROOT_M_LO];
    wire [1:0] adc_code = root_m_adc_reg[`F_ADC_HI:`F_ADC_LO];
    wire [1:0] dac_code = dac_bclk_hi_reg[`F_DAC_HI:`F_DAC_LO];
    wire [8:0] pri_code = {dac_bclk_hi_reg[`F_PRI_HI], pri_lo_reg};
    wire [8:0] sec_code = {dac_bclk_hi_reg[`F_SEC_HI], sec_lo_reg};
    wire [5:0] ana_code = analog_nm_reg[`F_ANA_HI:`F_ANA_LO];

    // Modulator code: 0,1,2 map to 1,2,4; reserved 3 treated as 1
    // Falling back to no division keeps a bad write harmless
    function [8:0] mod_div;
        input [1:0] c;
        begin
            case (c)
                2'd1: mod_div = 9'd2;
                2'd2: mod_div = 9'd4;
                default: mod_div = 9'd1;
            endcase
        end
    endfunction

    // Power of two microphone code; reserved 5..7 treated as 1
    // Ratio 16 is the largest, so nine bits leave ample room
    function [8:0] mic_div;
        input [2:0] c;
        begin
            if (c <= 3'd4) begin
                mic_div = 9'd1 << c;
            end else begin
                mic_div = 9'd1;
            end
        end
    endfunction

    // Zero codes stand for the largest ratio of each field; the bit
    // clock ratios need ten bits since their code zero means 512
    wire [8:0] n_prog = (n_code == 3'd0) ? 9'd8 : {6'd0, n_code};
    wire [8:0] m_prog = (m_code == 6'd0) ? 9'd64 : {3'd0, m_code};
    wire [8:0] a_prog = (ana_code == 6'd0) ? 9'd64 : {3'd0, ana_code};
    wire [9:0] p_prog = (pri_code == 9'd0) ? 10'd512 : {1'b0, pri_code};
    wire [9:0] s_prog = (sec_code == 9'd0) ? 10'd512 : {1'b0, sec_code};
    // Double rate halves the DAC ratio; ratio 1 cannot be halved further
    // Double rate is the reset state, since the off bit resets clear
    wire dac_x2 = !dac_bclk_hi_reg[`F_DAC_X2_OFF];
    wire [8:0] dac_base = mod_div(dac_code);
    wire [8:0] dac_prog = (dac_x2 && dac_base > 9'd1) ? (dac_base >> 1)
                                                       : dac_base;

    // Effective ratios: auto mode substitutes internal choices
    // The AUTO_* values stand in for what the rate detector would pick;
    // the detector itself is not part of this block
    wire [9:0] ratio [0:7];
    assign ratio[0] = {1'b0, auto_on ? AUTO_N : n_prog};
    assign ratio[1] = {1'b0, auto_on ? AUTO_M : m_prog};
    assign ratio[2] = {1'b0, auto_on ? AUTO_MIC : mic_div(mic_code)};
    assign ratio[3] = {1'b0, auto_on ? AUTO_MOD : mod_div(adc_code)};
    assign ratio[4] = {1'b0, auto_on ? AUTO_MOD : dac_prog};
    assign ratio[5] = auto_on ? AUTO_BCLK : p_prog;
    assign ratio[6] = auto_on ? AUTO_BCLK : s_prog;
    assign ratio[7] = {1'b0, auto_on ? AUTO_ANA : a_prog};

    // Enables: only N, M and microphone dividers have their own bits
    // An enable change acts at the next edge; a stopped tap rests low
    // and restarts from a clear count, so its first period is whole
    wire [7:0] run = {5'b11111, enables_reg[`F_EN_MIC],
                      enables_reg[`F_EN_M], enables_reg[`F_EN_N]};
    wire [7:0] run_ord = {run[7:3], run[2], run[1], run[0]};

    // Divided clocks: high for the first half of each period of the tap.
    // Each tap counts pclk cycles from zero to its ratio less one and
    // drives high while the count sits below half the ratio, so even
    // ratio two gives one high and one low cycle. A ratio change in
    // mid-count is absorbed: a count already past the new end wraps at
    // once, so one odd period may appear but the tap never stalls.
    // Ratio one cannot be made from pclk itself; the tap toggles each
    // cycle instead, which gives half the input rate. Each tap owns its
    // counter and flop, so no register has more than one writer.
    wire [7:0] clk_bits; // One divided clock per tap
    genvar g;
    generate
        for (g = 0; g < 8; g = g + 1) begin : div
            wire [9:0] half = {1'b0, ratio[g][9:1]}; // High phase length
            reg [9:0] cnt_reg; // Position within the current period
            reg tap_reg; // Divided clock of this tap
            assign clk_bits[g] = tap_reg;
            // Count and shape; a stopped tap rests low with a clear count
            always @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    cnt_reg <= 10'h000;
                    tap_reg <= 1'b0;
                end else if (!run_ord[g]) begin
                    cnt_reg <= 10'h000;
                    tap_reg <= 1'b0;
                end else if (ratio[g] == 10'd1) begin
                    cnt_reg <= 10'h000;
                    tap_reg <= ~tap_reg;
                end else begin
                    if (cnt_reg >= ratio[g] - 10'd1) begin
                        cnt_reg <= 10'h000;
                    end else begin
                        cnt_reg <= cnt_reg + 10'd1;
                    end
                    tap_reg <= (cnt_reg < half);
                end
            end
        end
    endgenerate

    // Outputs straight from the tap flip-flops
    always @* begin
        root_n_clk = clk_bits[0];
        root_m_clk = clk_bits[1];
        mic_clk = clk_bits[2];
        adc_mod_clk = clk_bits[3];
        dac_mod_clk = clk_bits[4];
        pri_bclk = clk_bits[5];
        sec_bclk = clk_bits[6];
        analog_nm_clk = clk_bits[7];
    end

endmodule // audio_clock_divider_config

// ==== dv/acd_monitor.sv ====
`timescale 1ns/1ps
// Checks the register handshake and the gating of enabled dividers
module acd_monitor (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    input wire [31:0] prdata,
    input wire pready,
    input wire pslverr,
    input wire auto_detect_pin,
    input wire auto_active,
    input wire root_n_clk,
    input wire root_m_clk,
    input wire mic_clk
);
    reg [2:0] en_reg; // Enable bits as last written
    reg [2:0] en_q_reg; // Same, one cycle older
    // Mirror on the storing edge, so off means off for two cycles
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            en_reg <= 3'h0;
            en_q_reg <= 3'h0;
        end else begin
            if (psel && penable && pready && pwrite && paddr == 12'h110)
                en_reg <= pwdata[2:0];
            en_q_reg <= en_reg;
        end
    end
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    a_ready_pulse: assert property (pready |=> !pready)
        else $error("pready held too long");
    a_ready_wait: assert property (psel && penable && !pready |=> pready)
        else $error("no answer one cycle after access");
    a_ready_cause: assert property (pready |-> $past(psel && penable))
        else $error("pready without access");
    a_err_ready: assert property (pslverr |-> pready)
        else $error("pslverr outside answer");
    a_err_misalign: assert property (psel && penable && !pready
        && paddr[1:0] != 2'h0 |=> pslverr)
        else $error("misaligned access not refused");
    a_n_gated: assert property (!en_reg[2] && !en_q_reg[2] |-> !root_n_clk)
        else $error("root N clock runs while off");
    a_m_gated: assert property (!en_reg[1] && !en_q_reg[1] |-> !root_m_clk)
        else $error("root M clock runs while off");
    a_mic_gated: assert property (!en_reg[0] && !en_q_reg[0] |-> !mic_clk)
        else $error("mic clock runs while off");
    a_auto_sync: assert property (auto_detect_pin [*6] |-> auto_active)
        else $error("auto pin not taken within six cycles");
endmodule // acd_monitor

// ==== dv/tb_top.sv ====
`timescale 1ns/1ps
module tb_top;
    logic pclk, presetn, psel, penable, pwrite, auto_detect_pin, er;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic pready, pslverr, auto_active;
    logic root_n_clk, root_m_clk, mic_clk, adc_mod_clk, dac_mod_clk;
    logic pri_bclk, sec_bclk, analog_nm_clk;
    wire [7:0] ck = {analog_nm_clk, sec_bclk, pri_bclk, dac_mod_clk,
        adc_mod_clk, mic_clk, root_m_clk, root_n_clk}; // Divider taps
    int n_mismatch = 0;
    int checks = 0;
    // Row: byte address, write flag, write data, expected read-back
    typedef struct {logic [11:0] a; logic w; logic [7:0] d, e;} row_t;
    row_t rows[12] = '{
        '{12'h0E4, 1'h0, 8'h00, 8'h20}, '{12'h0E8, 1'h0, 8'h00, 8'h04},
        '{12'h0EC, 1'h0, 8'h00, 8'h00}, '{12'h0F0, 1'h0, 8'h00, 8'h01},
        '{12'h0F4, 1'h0, 8'h00, 8'h01}, '{12'h0F8, 1'h0, 8'h00, 8'h01},
        '{12'h110, 1'h0, 8'h00, 8'h00}, '{12'h0E4, 1'h1, 8'hFF, 8'hFC},
        '{12'h0EC, 1'h1, 8'hFF, 8'h3E}, '{12'h0F8, 1'h1, 8'hFF, 8'h3F},
        '{12'h110, 1'h1, 8'hFF, 8'h07}, '{12'h0E8, 1'h1, 8'hFF, 8'hFF}};
    audio_clock_divider_config uut (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .auto_detect_pin(auto_detect_pin),
        .root_n_clk(root_n_clk), .root_m_clk(root_m_clk),
        .mic_clk(mic_clk), .adc_mod_clk(adc_mod_clk),
        .dac_mod_clk(dac_mod_clk), .pri_bclk(pri_bclk),
        .sec_bclk(sec_bclk), .analog_nm_clk(analog_nm_clk),
        .auto_active(auto_active));
    // 100 MHz clock
    initial begin
        pclk = 1'h0;
        forever #5 pclk = ~pclk;
    end
    task chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    // One APB transfer; waits for pready as long as it takes, the
    // watchdog being the only limit on a slave that never answers
    task xfer(input logic [11:0] a, input logic w, input logic [31:0] d);
        begin
            @(posedge pclk);
            {psel, penable, pwrite, paddr, pwdata} <= {2'h2, w, a, d};
            @(posedge pclk);
            penable <= 1'h1;
            do begin
                @(posedge pclk);
            end while (pready !== 1'h1);
            rd = prdata;
            er = pslverr;
            {psel, penable} <= 2'h0;
        end
    endtask
    // Period in pclk cycles; the first period is skipped since a new
    // setting may land in mid-count. Zero expected ratio means idle.
    task per(input int i, input int r);
        int t, c, k;
        logic p;
        begin
            t = 0;
            c = 0;
            p = ck[i];
            for (k = 0; k < 1800 && c < 3; k++) begin
                @(negedge pclk);
                if (c == 2) t++;
                if (ck[i] === 1'h1 && p === 1'h0) c++;
                p = ck[i];
            end
            chk(t, (r == 0) ? 0 : (r == 1) ? 2 : r);
            if (r == 0) chk(32'(ck[i]), 32'h0);
        end
    endtask
    task stop_test;
        $display("checks %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    // Watchdog; the run needs about 10,000 cycles, this allows three times
    initial begin
        #300000;
        n_mismatch++;
        stop_test;
    end
    initial begin
        {psel, penable, pwrite, auto_detect_pin, presetn} = 5'h00;
        paddr = 12'h000;
        pwdata = 32'h0;
        repeat (10) @(posedge pclk);
        presetn <= 1'h1;
        foreach (rows[i]) begin
            if (rows[i].w) xfer(rows[i].a, 1'h1, {24'hFFFFFF, rows[i].d});
            xfer(rows[i].a, 1'h0, 32'h0);
            chk(rd, {24'h0, rows[i].e});
        end
        $display("register rows done");
        xfer(12'h0E4, 1'h1, 32'h10);
        per(0, 8);
        per(2, 16);
        xfer(12'h0E8, 1'h1, 32'h02);
        per(1, 64);
        per(3, 4);
        xfer(12'h0EC, 1'h1, 32'h28);
        xfer(12'h0F0, 1'h1, 32'h00);
        per(4, 4);
        per(5, 512);
        per(6, 1);
        xfer(12'h0EC, 1'h1, 32'h26);
        per(4, 2);
        per(5, 256);
        per(6, 257);
        xfer(12'h0F8, 1'h1, 32'h00);
        per(7, 64);
        $display("divide ratios done");
        @(posedge pclk);
        auto_detect_pin <= 1'h1;
        repeat (6) @(posedge pclk);
        chk(32'(auto_active), 32'h1);
        per(0, 1);
        per(5, 1);
        @(posedge pclk);
        auto_detect_pin <= 1'h0;
        $display("auto override done");
        xfer(12'h110, 1'h1, 32'h0);
        for (int i = 0; i < 3; i++) per(i, 0);
        $display("enable gating done");
        // Unmapped and misaligned places are refused and leave no trace
        xfer(12'h100, 1'h0, 32'h0);
        chk(rd, 32'h0);
        chk(32'(er), 32'h1);
        xfer(12'h0E5, 1'h1, 32'hFF);
        chk(32'(er), 32'h1);
        xfer(12'h0E4, 1'h0, 32'h0);
        chk(rd, 32'h10);
        $display("refusals done");
        presetn <= 1'h0;
        repeat (2) @(posedge pclk);
        presetn <= 1'h1;
        xfer(12'h0E4, 1'h0, 32'h0);
        chk(rd, 32'h20);
        $display("second reset done");
        stop_test;
    end
endmodule // tb_top
bind audio_clock_divider_config acd_monitor mon (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .auto_detect_pin(auto_detect_pin),
    .auto_active(auto_active), .root_n_clk(root_n_clk),
    .root_m_clk(root_m_clk), .mic_clk(mic_clk));
